// [clk_gen_defs.vh]
// constants for the clock generator core: register map, field positions,
// reset values and loop timing; assumes a 250 MHz system clock
`ifndef CLK_GEN_DEFS_VH
`define CLK_GEN_DEFS_VH

// register bus
`define ADDR_W 4
`define DATA_W 16
`define REG_CTRL 4'h0
`define REG_CONFIG 4'h1
`define REG_MULT 4'h2
`define REG_STATUS 4'h3
`define REG_DCO 4'h4
`define REG_IRQ_STAT 4'h5
`define REG_IRQ_MASK 4'h6

// control register fields
`define CTRL_INT_ON 0
`define CTRL_EXT_ON 1
`define CTRL_RST 2'h1

// configuration register fields
`define CFG_RUN_IN_STOP 0
`define CFG_EXT_ALLOWED 1
`define CFG_CRYSTAL 2
`define CFG_RST 3'h0

// multiplier register
`define MULT_W 8
`define MULT_RST 8'h01
`define MULT_ONE 8'h01

// event bits of the interrupt status and mask registers
`define IRQ_W 3
`define IRQ_LOCK 0
`define IRQ_UNLOCK 1
`define IRQ_RANGE 2

// oscillator control word
`define DCO_W 12
`define DCO_RST 12'h400
`define DCO_MAX 12'h9ff
`define DIV_SLOWEST 4'h9
`define STEP_FINE 12'h001
`define STEP_COARSE 12'h020
`define DCO_HALF_W 11

// timing: nominal base clock 307.2 kHz against a 4 ns system clock
`define MCLK_PERIOD_PS 4000
`define NOM_PERIOD_PS 3255208
`define NOM_PERIOD_CYC ((`NOM_PERIOD_PS + `MCLK_PERIOD_PS / 2) / `MCLK_PERIOD_PS)
`define SLOW_LIMIT_CYC ((`NOM_PERIOD_CYC * 100) / 85)
`define FAST_LIMIT_CYC ((`NOM_PERIOD_CYC * 100 + 114) / 115)
`define MEAS_W 20
`define MEAS_MAX 20'hf_ffff

`endif

// [clk_gen_core.v]
// clock generator core: clock enable circuit, digitally trimmed internal
// oscillator with modulo-N divider, frequency comparator and loop filter.
// assumes stop request and register port run on mclk_i; the oscillator
// pin is asynchronous and is synchronised here. all clocks out are levels
// sampled on mclk_i, so the internal clock is limited to mclk_i / 2.
// Notes on behaviour
// - bus clock is a quarter of oscillator output, half of generator output.
// - stop mode with run-in-stop clear asserts stop, halting all clocks.
// - run-in-stop set keeps clocks running, stop never asserted.
// - internal enable equals internal-on and not stop.
// - internal enable low holds internal and base clocks low.
// - external enable equals external-on and not stop; otherwise external clock low.
// - external-on cannot be set unless external clock is allowed.
// - pin A port enable low whenever external-on set, stop or not.
// - pin B port enable low whenever external-on and crystal enable set.
// - internal clock is N times base clock, base nominally 307.2 kHz.
// - oscillator period set by 12-bit divider:stage word, valid 000 to 9FF.
// - base clock is internal clock divided by N; N of 0 or 1 passes through.
// - correction -32, -1, +1, +32 by base clock error band.
// - divider and stage fields form one 12-bit accumulator with carry.
// - divider values A to F behave like 9, the slowest.
// - out-of-range value recovers only by normal subtraction steps.
// - stable flag set while base clock error within 15 percent.
// - crystal amplifier on only with external enable and crystal enable.
`include "clk_gen_defs.vh"
`default_nettype none

module clk_gen_core (
	// clock and reset
	input wire mclk_i,
	input wire rst_n_i,
	// register port
	input wire [`ADDR_W-1:0] addr_i,
	input wire [`DATA_W-1:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [`DATA_W-1:0] rdata_o,
	output reg irq_o,
	// system integration unit
	input wire stop_mode_i,
	output reg generator_stop_o,
	output reg internal_gen_enable_o,
	output reg external_gen_enable_o,
	// oscillator pins and shared port enables
	input wire oscillator_pin_a_i,
	output reg shared_pin_a_port_enable_o,
	output reg shared_pin_b_port_enable_o,
	output reg crystal_amp_enable_o,
	// generated clocks
	output reg internal_clock_o,
	output reg base_clock_o,
	output reg external_clock_o,
	output reg oscillator_output_clock_o,
	output reg generator_output_clock_o,
	output reg bus_clock_o,
	output reg timebase_clock_o,
	// loop state
	output reg filter_stable_flag_o
);

	function rise;
		input now;
		input prev;
		begin
			rise = now & ~prev;
		end
	endfunction

	// software registers
	reg [1:0] ctrl_r;
	reg [2:0] cfg_r;
	reg [`MULT_W-1:0] mult_r;
	reg [`IRQ_W-1:0] irq_stat_r;
	reg [`IRQ_W-1:0] irq_mask_r;
	// loop state
	reg [`DCO_W-1:0] dco_r;
	reg [`DCO_HALF_W-1:0] half_cnt_r;
	reg internal_clock_r;
	reg [`MULT_W-1:0] div_cnt_r;
	reg base_r;
	reg [`MEAS_W-1:0] meas_r;
	reg meas_valid_r;
	reg stable_r;
	// external pin synchroniser
	reg pin_a_meta_r;
	reg pin_a_sync_r;
	// derived clock chain
	reg osc_r;
	reg gen_r;
	reg bus_r;

	wire int_on = ctrl_r[`CTRL_INT_ON];
	wire ext_on = ctrl_r[`CTRL_EXT_ON];
	wire run_in_stop = cfg_r[`CFG_RUN_IN_STOP];
	wire ext_allowed = cfg_r[`CFG_EXT_ALLOWED];
	wire crystal = cfg_r[`CFG_CRYSTAL];

	wire gen_stop = stop_mode_i & ~run_in_stop;
	wire int_en = int_on & ~gen_stop;
	wire ext_en = ext_on & ~gen_stop;

	// divider values above 9 run as 9, the slowest setting
	wire [3:0] div_field = dco_r[`DCO_W-1:`DCO_W-4];
	wire [3:0] div_eff = (div_field > `DIV_SLOWEST) ? `DIV_SLOWEST : div_field;
	wire [`DCO_W-1:0] dco_eff = {div_eff, dco_r[`DCO_W-5:0]};
	// larger word gives a longer period; a quarter of the word keeps the
	// nominal rate reachable at small N against a 250 MHz sampling clock
	wire [`DCO_HALF_W-1:0] half_len = dco_eff[`DCO_W-1:2] + 11'h001;

	// internal oscillator model: toggles after half_len system cycles
	wire half_done = (half_cnt_r >= half_len - 11'h001);
	wire internal_clock_nxt = int_en ? (half_done ? ~internal_clock_r : internal_clock_r) : 1'b0;
	wire internal_clock_rise = rise(internal_clock_nxt, internal_clock_r);

	// modulo-N divider
	wire pass_through = (mult_r <= `MULT_ONE);
	wire [`MULT_W-1:0] div_last = mult_r - `MULT_ONE;
	wire [`MULT_W-1:0] div_cnt_nxt = (div_cnt_r >= div_last) ? {`MULT_W{1'b0}} :
		div_cnt_r + `MULT_ONE;
	wire [`MULT_W-1:0] high_len = mult_r >> 1;
	reg base_nxt;
	always @* begin
		base_nxt = base_r;
		if (!int_en)
			base_nxt = 1'b0;
		else if (pass_through)
			base_nxt = internal_clock_nxt;
		else if (internal_clock_rise)
			base_nxt = (div_cnt_nxt < high_len);
	end
	wire base_rise = rise(base_nxt, base_r);

	// frequency comparator: base period in system cycles against limits
	wire too_slow = meas_r > `SLOW_LIMIT_CYC;
	wire slow = meas_r > `NOM_PERIOD_CYC;
	wire too_fast = meas_r < `FAST_LIMIT_CYC;
	wire fast = meas_r < `NOM_PERIOD_CYC;
	wire judge = base_rise & meas_valid_r;

	// loop filter: one 12-bit accumulator, carry from stage into divider
	reg [`DCO_W-1:0] dco_nxt;
	always @* begin
		dco_nxt = dco_r;
		if (judge) begin
			if (too_slow)
				dco_nxt = dco_r - `STEP_COARSE;
			else if (slow)
				dco_nxt = dco_r - `STEP_FINE;
			else if (too_fast)
				dco_nxt = dco_r + `STEP_COARSE;
			else if (fast)
				dco_nxt = dco_r + `STEP_FINE;
		end
	end
	wire stable_nxt = judge ? ~(too_slow | too_fast) : (int_en ? stable_r : 1'b0);
	wire range_evt = (dco_nxt > `DCO_MAX) & (dco_r <= `DCO_MAX);

	// external clock and derived clock chain
	wire external_clock_nxt = ext_en & pin_a_sync_r;
	wire osc_nxt = int_on ? (internal_clock_nxt & int_en) : external_clock_nxt;
	wire gen_nxt = rise(osc_nxt, osc_r) ? ~gen_r : gen_r;
	wire bus_nxt = rise(gen_nxt, gen_r) ? ~bus_r : bus_r;
	wire tb_nxt = ext_en ? external_clock_nxt : base_nxt;

	// register writes
	wire wr_ctrl = wr_i & (addr_i == `REG_CTRL);
	wire wr_cfg = wr_i & (addr_i == `REG_CONFIG);
	wire wr_mult = wr_i & (addr_i == `REG_MULT);
	wire wr_istat = wr_i & (addr_i == `REG_IRQ_STAT);
	wire wr_imask = wr_i & (addr_i == `REG_IRQ_MASK);
	// setting is refused while not allowed; clearing is always accepted
	wire ext_on_nxt = wdata_i[`CTRL_EXT_ON] & (ext_allowed | ext_on);
	wire [`IRQ_W-1:0] irq_evt = {range_evt, stable_r & ~stable_nxt, stable_nxt & ~stable_r};
	wire [`IRQ_W-1:0] irq_clr = wr_istat ? wdata_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
	// a new event wins over a clear in the same cycle
	wire [`IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;

	reg [`DATA_W-1:0] rdata_nxt;
	always @* begin
		rdata_nxt = {`DATA_W{1'b0}};
		case (addr_i)
		`REG_CTRL: rdata_nxt[1:0] = ctrl_r;
		`REG_CONFIG: rdata_nxt[2:0] = cfg_r;
		`REG_MULT: rdata_nxt[`MULT_W-1:0] = mult_r;
		`REG_STATUS: rdata_nxt[3:0] = {gen_stop, ext_en, int_en, stable_r};
		`REG_DCO: rdata_nxt[`DCO_W-1:0] = dco_r;
		`REG_IRQ_STAT: rdata_nxt[`IRQ_W-1:0] = irq_stat_r;
		`REG_IRQ_MASK: rdata_nxt[`IRQ_W-1:0] = irq_mask_r;
		default: rdata_nxt = {`DATA_W{1'b0}};
		endcase
	end

	// register file and interrupt
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_r <= `CTRL_RST;
			cfg_r <= `CFG_RST;
			mult_r <= `MULT_RST;
			irq_stat_r <= {`IRQ_W{1'b0}};
			irq_mask_r <= {`IRQ_W{1'b0}};
			rdata_o <= {`DATA_W{1'b0}};
			irq_o <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_r[`CTRL_INT_ON] <= wdata_i[`CTRL_INT_ON];
				ctrl_r[`CTRL_EXT_ON] <= ext_on_nxt;
			end
			if (wr_cfg)
				cfg_r <= wdata_i[2:0];
			if (wr_mult)
				mult_r <= wdata_i[`MULT_W-1:0];
			if (wr_imask)
				irq_mask_r <= wdata_i[`IRQ_W-1:0];
			irq_stat_r <= irq_stat_nxt;
			irq_o <= |(irq_stat_nxt & (wr_imask ? wdata_i[`IRQ_W-1:0] : irq_mask_r));
			rdata_o <= rd_i ? rdata_nxt : {`DATA_W{1'b0}};
		end
	end

	// oscillator, divider and loop filter
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dco_r <= `DCO_RST;
			half_cnt_r <= {`DCO_HALF_W{1'b0}};
			internal_clock_r <= 1'b0;
			div_cnt_r <= {`MULT_W{1'b0}};
			base_r <= 1'b0;
			meas_r <= {`MEAS_W{1'b0}};
			meas_valid_r <= 1'b0;
			stable_r <= 1'b0;
		end else begin
			internal_clock_r <= internal_clock_nxt;
			base_r <= base_nxt;
			dco_r <= dco_nxt;
			stable_r <= stable_nxt;
			if (!int_en || half_done)
				half_cnt_r <= {`DCO_HALF_W{1'b0}};
			else
				half_cnt_r <= half_cnt_r + 11'h001;
			if (!int_en || pass_through)
				div_cnt_r <= {`MULT_W{1'b0}};
			else if (internal_clock_rise)
				div_cnt_r <= div_cnt_nxt;
			// the first period after enabling is partial, so it is not judged
			if (!int_en) begin
				meas_r <= {`MEAS_W{1'b0}};
				meas_valid_r <= 1'b0;
			end else if (base_rise) begin
				meas_r <= 20'h0_0001;
				meas_valid_r <= 1'b1;
			end else if (meas_r != `MEAS_MAX) begin
				meas_r <= meas_r + 20'h0_0001;
			end
		end
	end

	// pin synchroniser and clock outputs
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_a_meta_r <= 1'b0;
			pin_a_sync_r <= 1'b0;
			osc_r <= 1'b0;
			gen_r <= 1'b0;
			bus_r <= 1'b0;
			generator_stop_o <= 1'b0;
			internal_gen_enable_o <= 1'b0;
			external_gen_enable_o <= 1'b0;
			shared_pin_a_port_enable_o <= 1'b1;
			shared_pin_b_port_enable_o <= 1'b1;
			crystal_amp_enable_o <= 1'b0;
			internal_clock_o <= 1'b0;
			base_clock_o <= 1'b0;
			external_clock_o <= 1'b0;
			oscillator_output_clock_o <= 1'b0;
			generator_output_clock_o <= 1'b0;
			bus_clock_o <= 1'b0;
			timebase_clock_o <= 1'b0;
			filter_stable_flag_o <= 1'b0;
		end else begin
			pin_a_meta_r <= oscillator_pin_a_i;
			pin_a_sync_r <= pin_a_meta_r;
			osc_r <= osc_nxt;
			gen_r <= gen_nxt;
			bus_r <= bus_nxt;
			generator_stop_o <= gen_stop;
			internal_gen_enable_o <= int_en;
			external_gen_enable_o <= ext_en;
			shared_pin_a_port_enable_o <= ~ext_on;
			shared_pin_b_port_enable_o <= ~(ext_on & crystal);
			crystal_amp_enable_o <= ext_en & crystal;
			internal_clock_o <= internal_clock_nxt;
			base_clock_o <= base_nxt;
			external_clock_o <= external_clock_nxt;
			oscillator_output_clock_o <= osc_nxt;
			generator_output_clock_o <= gen_nxt;
			bus_clock_o <= bus_nxt;
			timebase_clock_o <= tb_nxt;
			filter_stable_flag_o <= stable_nxt;
		end
	end

endmodule

`default_nettype wire

// [clk_gen_props.sv]
// checker for the clock generator core, watching its ports only
// assumes one clock domain and a bind onto every clk_gen_core
`include "clk_gen_defs.vh"
`default_nettype none
module clk_gen_props (
	// clock and reset
	input wire mclk_i,
	input wire rst_n_i,
	// register port
	input wire [`ADDR_W-1:0] addr_i,
	input wire [`DATA_W-1:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [`DATA_W-1:0] rdata_o,
	// enables and clocks
	input wire stop_mode_i,
	input wire generator_stop_o,
	input wire internal_gen_enable_o,
	input wire external_gen_enable_o,
	input wire shared_pin_a_port_enable_o,
	input wire shared_pin_b_port_enable_o,
	input wire crystal_amp_enable_o,
	input wire internal_clock_o,
	input wire base_clock_o,
	input wire external_clock_o,
	input wire filter_stable_flag_o
);
	// shadow of control and config bits, rebuilt from bus writes
	reg int_on_r, ext_on_r, run_r, allow_r, xtal_r;
	wire stp = stop_mode_i & ~run_r;
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{int_on_r, ext_on_r, run_r, allow_r, xtal_r} <= 5'h10;
		end else if (wr_i && addr_i == `REG_CTRL) begin
			int_on_r <= wdata_i[0];
			ext_on_r <= wdata_i[1] & (allow_r | ext_on_r);
		end else if (wr_i && addr_i == `REG_CONFIG) begin
			{xtal_r, allow_r, run_r} <= wdata_i[2:0];
		end
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	// first edge after reset sees pre-reset history, so each $past check except chk_int_low waits one edge
	chk_stop_follow: assert property ($past(rst_n_i) |-> generator_stop_o == $past(stp))
		else $error("stop output does not follow stop request");
	chk_int_enable: assert property ($past(rst_n_i) |-> internal_gen_enable_o == $past(int_on_r & ~stp))
		else $error("internal enable wrong");
	chk_int_low: assert property (!internal_gen_enable_o && !$past(internal_gen_enable_o)
		|-> !internal_clock_o && !base_clock_o)
		else $error("internal clocks run while disabled");
	chk_ext_enable: assert property ($past(rst_n_i) |-> external_gen_enable_o == $past(ext_on_r & ~stp))
		else $error("external enable wrong");
	chk_ext_low: assert property (!external_gen_enable_o [*2] |-> !external_clock_o)
		else $error("external clock runs while disabled");
	chk_pin_a_port: assert property ($past(rst_n_i) |-> shared_pin_a_port_enable_o == !$past(ext_on_r))
		else $error("pin a port enable wrong");
	chk_pin_b_port: assert property ($past(rst_n_i)
		|-> shared_pin_b_port_enable_o == !$past(ext_on_r & xtal_r))
		else $error("pin b port enable wrong");
	chk_amp_enable: assert property ($past(rst_n_i)
		|-> crystal_amp_enable_o == $past(ext_on_r & ~stp & xtal_r))
		else $error("crystal amplifier enable wrong");
	chk_flag_at_edge: assert property ($changed(filter_stable_flag_o) |-> $rose(base_clock_o))
		else $error("stable flag moved between base edges");
	chk_rdata_idle: assert property ($past(rst_n_i) && !$past(rd_i) |-> rdata_o == '0)
		else $error("read data outside read slot");
	cover property ($rose(filter_stable_flag_o));
	cover property ($rose(generator_stop_o));
	cover property ($rose(external_gen_enable_o));
endmodule
bind clk_gen_core clk_gen_props i_clk_gen_props (.*);
`default_nettype wire

// [ext_osc_model.sv]
// external clock source standing on oscillator pin a
// assumes the bench switches it; a real source runs free, so no framing
`default_nettype none
module ext_osc_model #(parameter int HALF_NS = 22) (
	input wire logic run_i,
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// half period is 5.5 system cycles, but the 44 ns period is 11 cycles, so the phase repeats
	initial pin_o = 1'h0;
	always #(HALF_NS) pin_o = run_i ? ~pin_o : 1'h0;
endmodule
`default_nettype wire

// [tb_clk_gen_core.sv]
// self-checking bench for the clock generator core
// assumes the external source model on pin a and the bound checker
`include "clk_gen_defs.vh"
`default_nettype none
module tb_clk_gen_core;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk_i = 1'h0, rst_n_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
	logic stop_mode_i = 1'h0, ext_run = 1'h0, cnt_en = 1'h0;
	logic [`ADDR_W-1:0] addr_i = '0;
	logic [`DATA_W-1:0] wdata_i = '0, d;
	logic [5:0] prev = '0;
	wire [`DATA_W-1:0] rdata_o;
	wire irq_o, generator_stop_o, internal_gen_enable_o, external_gen_enable_o;
	wire shared_pin_a_port_enable_o, shared_pin_b_port_enable_o, crystal_amp_enable_o;
	wire internal_clock_o, base_clock_o, external_clock_o, oscillator_output_clock_o;
	wire generator_output_clock_o, bus_clock_o, timebase_clock_o, filter_stable_flag_o;
	wire oscillator_pin_a_i;
	int n_fail = 0, compares = 0, cyc = 0, n_i, n_b, n_o, n_g, n_u, n_t;
	clk_gen_core i_clk_gen_core (.*);
	ext_osc_model i_ext_osc_model (.run_i(ext_run), .pin_o(oscillator_pin_a_i));
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		prev <= {internal_clock_o, base_clock_o, oscillator_output_clock_o,
			generator_output_clock_o, bus_clock_o, timebase_clock_o};
		if (cnt_en) begin
			n_i <= n_i + (internal_clock_o & !prev[5]);
			n_b <= n_b + (base_clock_o & !prev[4]);
			n_o <= n_o + (oscillator_output_clock_o & !prev[3]);
			n_g <= n_g + (generator_output_clock_o & !prev[2]);
			n_u <= n_u + (bus_clock_o & !prev[1]);
			n_t <= n_t + (timebase_clock_o & !prev[0]);
		end
	end
	task automatic results();
		if (n_fail == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [`DATA_W-1:0] e, g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rng(input string nm, input logic [31:0] lo, hi, g);
		compares++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			n_fail++;
			$display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] v);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'h1;
		@(posedge mclk_i);
		wr_i <= 1'h0;
	endtask
	task automatic rdc(input string nm, input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge mclk_i);
		rd_i <= 1'h0;
		#1 d = rdata_o;
		if (nm != "") chk(nm, e, d);
	endtask
	task automatic count(input int c);
		{n_i, n_b, n_o, n_g, n_u, n_t} = '0;
		#1 cnt_en = 1'h1;
		repeat (c) @(posedge mclk_i);
		#1 cnt_en = 1'h0;
	endtask
	task automatic stop_for(input logic s);
		@(posedge mclk_i);
		stop_mode_i <= s;
		repeat (3) @(posedge mclk_i);
		#1;
	endtask
	initial begin
		wait (cyc == 90000);
		n_fail++;
		results();
	end
	initial begin
		repeat (5) @(posedge mclk_i);
		rst_n_i <= 1'h1;
		rdc("dco", `REG_DCO, 16'h0400);
		rdc("ctrl", `REG_CTRL, 16'h0001);
		rdc("config", `REG_CONFIG, 16'h0000);
		rdc("mult", `REG_MULT, 16'h0001);
		rdc("mask", `REG_IRQ_MASK, 16'h0000);
		rdc("unmapped", 4'h7, 16'h0000);
		wr(`REG_CTRL, 16'h0003);
		rdc("ctrl", `REG_CTRL, 16'h0001);
		stop_for(1'h1);
		chk("stop", 16'h0001, generator_stop_o);
		chk("int clk", 16'h0000, internal_clock_o);
		wr(`REG_CONFIG, 16'h0001);
		stop_for(1'h1);
		chk("stop", 16'h0000, generator_stop_o);
		chk("int en", 16'h0001, internal_gen_enable_o);
		stop_for(1'h0);
		wr(`REG_CONFIG, 16'h0006);
		wr(`REG_CTRL, 16'h0002);
		ext_run <= 1'h1;
		rdc("ctrl", `REG_CTRL, 16'h0002);
		chk("pin a", 16'h0000, shared_pin_a_port_enable_o);
		chk("amp", 16'h0001, crystal_amp_enable_o);
		// 44 ns source period is 11 system cycles: 400 rises in 4400 cycles
		count(4400);
		rng("osc", 380, 420, n_o);
		rng("gen", n_o / 2 - 1, n_o / 2 + 1, n_g);
		rng("bus", n_o / 4 - 1, n_o / 4 + 1, n_u);
		rng("int", 0, 0, n_i);
		rng("timebase", n_o - 1, n_o + 1, n_t);
		stop_for(1'h1);
		chk("ext en", 16'h0000, external_gen_enable_o);
		chk("pin b", 16'h0000, shared_pin_b_port_enable_o);
		stop_for(1'h0);
		wr(`REG_CTRL, 16'h0001);
		ext_run <= 1'h0;
		wr(`REG_IRQ_STAT, 16'h0007);
		wr(`REG_IRQ_MASK, 16'h0001);
		for (int k = 0; k < 60000 && filter_stable_flag_o !== 1'b1; k++) @(posedge mclk_i);
		#1 chk("stable", 16'h0001, filter_stable_flag_o);
		// stable band 708..957 cycles maps to word 0x584..0x777, plus one step of slack
		rdc("", `REG_DCO, 16'h0000);
		rng("dco", 1400, 1920, {16'h0000, d});
		chk("irq", 16'h0001, irq_o);
		rdc("status", `REG_STATUS, 16'h0003);
		wr(`REG_IRQ_MASK, 16'h0000);
		@(posedge mclk_i);
		#1 chk("irq", 16'h0000, irq_o);
		wr(`REG_IRQ_STAT, 16'h0001);
		rdc("", `REG_IRQ_STAT, 16'h0000);
		chk("stat", 16'h0000, d & 16'h0001);
		wr(`REG_MULT, 16'h0003);
		count(16000);
		rng("base", n_i / 3 - 1, n_i / 3 + 1, n_b);
		wr(`REG_MULT, 16'h0000);
		count(8000);
		rng("base", n_i - 1, n_i + 1, n_b);
		results();
	end
endmodule
`default_nettype wire
